// ===== pkg/bkt_defs.vh
`ifndef BKT_DEFS_VH
`define BKT_DEFS_VH

// Register addresses on the control interface
`define BKT_ADDR_RUN_SP 8'h35
`define BKT_ADDR_STBY_SP 8'h36
`define BKT_ADDR_SLEEP_SP 8'h37
`define BKT_ADDR_MODE 8'h38
`define BKT_ADDR_TUNE 8'h39

// Set point field layout
`define BKT_SP_CODE_MSB 5
`define BKT_SP_CODE_LSB 0
`define BKT_SP_RANGE_BIT 6
`define BKT_SP_RESET 6'h00

// Mode register layout
`define BKT_MODE_SEL_MSB 3
`define BKT_MODE_SEL_LSB 0
`define BKT_MODE_SLEEP_BIT 5
`define BKT_MODE_SEL_RESET 4'h0
`define BKT_MODE_SLEEP_OFF 1'b0
`define BKT_MODE_SLEEP_PFM 1'b1

// Tuning register layout
`define BKT_TUNE_ILIM_BIT 0
`define BKT_TUNE_SPARE_BIT 1
`define BKT_TUNE_FREQ_MSB 3
`define BKT_TUNE_FREQ_LSB 2
`define BKT_TUNE_PHASE_MSB 5
`define BKT_TUNE_PHASE_LSB 4
`define BKT_TUNE_RAMP_MSB 7
`define BKT_TUNE_RAMP_LSB 6
`define BKT_TUNE_RESET 8'h00

// Power state encoding, one-hot
`define BKT_PST_RUN 3'h1
`define BKT_PST_STBY 3'h2
`define BKT_PST_SLEEP 3'h4

`endif

// ===== rtl/bkt_field.v
`timescale 1ns/1ps
// One writable register field with reset value and write strobe
module bkt_field #(
	parameter WIDTH = 6,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire i_clk,
	input wire i_rst_b,
	input wire i_we,
	input wire [WIDTH-1:0] i_wdata,
	output reg [WIDTH-1:0] o_q
);

	// Field storage, loaded only on its own strobe
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_q <= RESET_VAL;
		end else if (i_we) begin
			o_q <= i_wdata;
		end
	end

endmodule // bkt_field

// ===== rtl/bkt_buck_two_regs.v
// Operation
// - Host reaches all registers over control interface
// - 0x35 bits 5:0 run set point, reset zero
// - 0x35 bit 6 range, test-load only
// - 0x36 bits 5:0 standby set point
// - 0x36 bit 6 mirrors range bit
// - 0x37 bits 5:0 sleep set point
// - 0x37 bit 6 copies range bit
// - 0x38 bits 3:0 switching mode select
// - 0x38 bit 5 sleep off or PFM
// - 0x39 bit 0 current limit select
// - 0x39 bits 3:2 switching frequency
// - 0x39 bits 5:4 phase clock select
// - 0x39 bits 7:6 voltage ramp speed
`timescale 1ns/1ps
`include "bkt_defs.vh"
module bkt_buck_two_regs (
	input wire I_SYS_CLK,
	input wire I_RST_B,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	output reg [7:0] o_reg_rdata,
	output reg o_reg_rd_hit,
	input wire i_test_cfg_we,
	input wire i_test_cfg_range,
	input wire i_pwr_standby,
	input wire i_pwr_sleep,
	output reg [5:0] o_active_setpoint,
	output reg o_voltage_range,
	output reg o_regulator_on,
	output reg o_sleep_pfm,
	output wire [3:0] o_switching_mode_select,
	output wire o_current_limit_select,
	output wire [1:0] o_switch_frequency_select,
	output wire [1:0] o_phase_clock_select,
	output wire [1:0] o_voltage_ramp_speed
);

	// Decoded write strobes, one per register
	wire we_run = i_reg_wr && (i_reg_addr == `BKT_ADDR_RUN_SP);
	wire we_stby = i_reg_wr && (i_reg_addr == `BKT_ADDR_STBY_SP);
	wire we_sleep = i_reg_wr && (i_reg_addr == `BKT_ADDR_SLEEP_SP);
	wire we_mode = i_reg_wr && (i_reg_addr == `BKT_ADDR_MODE);
	wire we_tune = i_reg_wr && (i_reg_addr == `BKT_ADDR_TUNE);

	// Stored fields
	wire [5:0] run_sp_q;
	wire [5:0] stby_sp_q;
	wire [5:0] sleep_sp_q;
	wire [4:0] mode_q; // Bit 4 is the sleep state select, 3:0 mode
	wire [7:0] tune_q;
	reg range_q; // Voltage range, shared by all three set points

	// Run set point code
	bkt_field #(.WIDTH(6), .RESET_VAL(`BKT_SP_RESET)) u_run (
		.i_clk(I_SYS_CLK),
		.i_rst_b(I_RST_B),
		.i_we(we_run),
		.i_wdata(i_reg_wdata[`BKT_SP_CODE_MSB:`BKT_SP_CODE_LSB]),
		.o_q(run_sp_q)
	);

	// Standby set point code
	bkt_field #(.WIDTH(6), .RESET_VAL(`BKT_SP_RESET)) u_stby (
		.i_clk(I_SYS_CLK),
		.i_rst_b(I_RST_B),
		.i_we(we_stby),
		.i_wdata(i_reg_wdata[`BKT_SP_CODE_MSB:`BKT_SP_CODE_LSB]),
		.o_q(stby_sp_q)
	);

	// Sleep set point code
	bkt_field #(.WIDTH(6), .RESET_VAL(`BKT_SP_RESET)) u_sleep (
		.i_clk(I_SYS_CLK),
		.i_rst_b(I_RST_B),
		.i_we(we_sleep),
		.i_wdata(i_reg_wdata[`BKT_SP_CODE_MSB:`BKT_SP_CODE_LSB]),
		.o_q(sleep_sp_q)
	);

	// Mode select and sleep behaviour packed; bit 4 of the pack is bus bit 5
	bkt_field #(.WIDTH(5), .RESET_VAL({`BKT_MODE_SLEEP_OFF, `BKT_MODE_SEL_RESET})) u_mode (
		.i_clk(I_SYS_CLK),
		.i_rst_b(I_RST_B),
		.i_we(we_mode),
		.i_wdata({i_reg_wdata[`BKT_MODE_SLEEP_BIT],
			i_reg_wdata[`BKT_MODE_SEL_MSB:`BKT_MODE_SEL_LSB]}),
		.o_q(mode_q)
	);

	// Tuning register, all eight bits writable including the spare bit
	bkt_field #(.WIDTH(8), .RESET_VAL(`BKT_TUNE_RESET)) u_tune (
		.i_clk(I_SYS_CLK),
		.i_rst_b(I_RST_B),
		.i_we(we_tune),
		.i_wdata(i_reg_wdata),
		.o_q(tune_q)
	);

	// Range bit: the host cannot write it; only the test load path can
	always @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			range_q <= 1'b0;
		end else if (i_test_cfg_we) begin
			range_q <= i_test_cfg_range;
		end
	end

	// Field outputs straight from storage
	assign o_switching_mode_select = mode_q[3:0];
	assign o_current_limit_select = tune_q[`BKT_TUNE_ILIM_BIT];
	assign o_switch_frequency_select = tune_q[`BKT_TUNE_FREQ_MSB:`BKT_TUNE_FREQ_LSB];
	assign o_phase_clock_select = tune_q[`BKT_TUNE_PHASE_MSB:`BKT_TUNE_PHASE_LSB];
	assign o_voltage_ramp_speed = tune_q[`BKT_TUNE_RAMP_MSB:`BKT_TUNE_RAMP_LSB];

	// Power state; sleep outranks standby when both are asserted
	wire [2:0] pstate = i_pwr_sleep ? `BKT_PST_SLEEP :
		(i_pwr_standby ? `BKT_PST_STBY : `BKT_PST_RUN);

	// Select the set point for the present power state, registered so the
	// analog side never sees a glitch between codes
	always @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_active_setpoint <= `BKT_SP_RESET;
			o_voltage_range <= 1'b0;
			o_regulator_on <= 1'b1;
			o_sleep_pfm <= 1'b0;
		end else begin
			o_voltage_range <= range_q;
			case (pstate)
				`BKT_PST_RUN: begin
					o_active_setpoint <= run_sp_q;
					o_regulator_on <= 1'b1;
					o_sleep_pfm <= 1'b0;
				end
				`BKT_PST_STBY: begin
					o_active_setpoint <= stby_sp_q;
					o_regulator_on <= 1'b1;
					o_sleep_pfm <= 1'b0;
				end
				`BKT_PST_SLEEP: begin
					o_active_setpoint <= sleep_sp_q;
					o_regulator_on <= mode_q[4];
					o_sleep_pfm <= mode_q[4];
				end
				default: begin
					o_active_setpoint <= run_sp_q;
					o_regulator_on <= 1'b1;
					o_sleep_pfm <= 1'b0;
				end
			endcase
		end
	end

	// Read data, registered one cycle after the strobe; unused bits zero, except the spare bit of 0x39, which reads back as written
	always @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			o_reg_rdata <= 8'h00;
			o_reg_rd_hit <= 1'b0;
		end else if (i_reg_rd) begin
			o_reg_rd_hit <= 1'b1;
			case (i_reg_addr)
				`BKT_ADDR_RUN_SP: o_reg_rdata <= {1'b0, range_q, run_sp_q};
				`BKT_ADDR_STBY_SP: o_reg_rdata <= {1'b0, range_q, stby_sp_q};
				`BKT_ADDR_SLEEP_SP: o_reg_rdata <= {1'b0, range_q, sleep_sp_q};
				`BKT_ADDR_MODE: o_reg_rdata <= {2'b00, mode_q[4], 1'b0, mode_q[3:0]};
				`BKT_ADDR_TUNE: o_reg_rdata <= tune_q;
				default: begin
					o_reg_rdata <= 8'h00; // Foreign address: not ours
					o_reg_rd_hit <= 1'b0;
				end
			endcase
		end else begin
			o_reg_rd_hit <= 1'b0;
		end
	end

endmodule // bkt_buck_two_regs

// ===== verif/bkt_host.sv
`timescale 1ns/1ps
// Host model: one byte per strobe, driven 1 ns after the edge
module bkt_host (
	input wire clk,
	output reg wr = 1'b0,
	output reg rd = 1'b0,
	output reg [7:0] addr = 8'h00,
	output reg [7:0] wdata = 8'h00
);
	// Strobe held across one sampling edge, then bus inverted so stale data never matches
	task xfer(input bit w, input [7:0] a, input [7:0] d);
		begin
			{wr, rd, addr, wdata} = {w, !w, a, d};
			@(posedge clk) #1;
			{wr, rd, addr, wdata} = {2'b00, ~a, ~d};
			// Idle edge, so a following call never re-drives a strobe in this time step
			@(posedge clk) #1;
		end
	endtask
endmodule // bkt_host

// ===== verif/bkt_chk_checker.sv
`timescale 1ns/1ps
// Timing relations on the register port and regulator controls
module bkt_chk (
	input wire I_SYS_CLK,
	input wire I_RST_B,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_pwr_sleep,
	input wire [7:0] o_reg_rdata,
	input wire o_reg_rd_hit,
	input wire o_regulator_on,
	input wire o_sleep_pfm,
	input wire [3:0] o_switching_mode_select
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_B);
	// Address falls in the mapped window
	wire hit = i_reg_addr >= 8'h35 && i_reg_addr <= 8'h39;
	sequence rd_in; i_reg_rd && hit; endsequence
	chk_read_hit: assert property (rd_in |=> o_reg_rd_hit)
		else $error("mapped read gave no hit");
	chk_hit_cause: assert property (o_reg_rd_hit |-> $past(i_reg_rd && hit))
		else $error("hit without read");
	chk_read_miss: assert property (i_reg_rd && !hit |=> !o_reg_rd_hit && o_reg_rdata == 8'h00)
		else $error("unmapped read not empty");
	chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read byte moved");
	chk_mode_write: assert property (i_reg_wr && i_reg_addr == 8'h38 |=>
		o_switching_mode_select == $past(i_reg_wdata[3:0]))
		else $error("mode field not written");
	chk_mode_unused: assert property (i_reg_rd && i_reg_addr == 8'h38 |=>
		(o_reg_rdata & 8'hD0) == 8'h00) else $error("unused mode bits set");
	chk_sleep_state: assert property (i_pwr_sleep |=> o_regulator_on == o_sleep_pfm)
		else $error("sleep state wrong");
	chk_run_state: assert property (!i_pwr_sleep |=> o_regulator_on && !o_sleep_pfm)
		else $error("awake state wrong");
endmodule // bkt_chk
bind bkt_buck_two_regs bkt_chk u_chk (.I_SYS_CLK, .I_RST_B, .i_reg_wr, .i_reg_rd, .i_reg_addr,
	.i_reg_wdata, .i_pwr_sleep, .o_reg_rdata, .o_reg_rd_hit, .o_regulator_on, .o_sleep_pfm,
	.o_switching_mode_select);

// ===== verif/bkt_buck_two_regs_tb_top.sv
`timescale 1ns/1ps
// Drives the bank through the host model; reads are scored from a queue
module bkt_buck_two_regs_tb_top;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg tcfg_we = 1'b0;
	reg tcfg_rng = 1'b0;
	reg stby = 1'b0;
	reg slp = 1'b0;
	reg rd_d = 1'b0;
	wire wr, rd, hit, rng, on, pfm;
	wire [7:0] addr, wdata, rdata;
	wire [5:0] act;
	wire [6:0] fld; // Ramp, phase, frequency, current limit fields
	wire [3:0] msel; // Switching mode field
	logic [8:0] expq[$];
	logic [7:0] v[5];
	int fails = 0;
	int num_checks = 0;
	always #4 clk = !clk;
	bkt_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
	bkt_buck_two_regs dut (.I_SYS_CLK(clk), .I_RST_B(rst_b), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rd_hit(hit),
		.i_test_cfg_we(tcfg_we), .i_test_cfg_range(tcfg_rng), .i_pwr_standby(stby),
		.i_pwr_sleep(slp), .o_active_setpoint(act), .o_voltage_range(rng), .o_regulator_on(on),
		.o_sleep_pfm(pfm), .o_switching_mode_select(msel), .o_current_limit_select(fld[0]),
		.o_switch_frequency_select(fld[2:1]), .o_phase_clock_select(fld[4:3]),
		.o_voltage_ramp_speed(fld[6:5]));
	task cmp(input string n, input logic [8:0] e, input logic [8:0] g);
		begin
			num_checks++;
			if (g !== e) begin
				fails++;
				$display("wrong value %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d fails %0d", num_checks, fails);
			if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Note the expected {hit, byte} before issuing the read
	task rdx(input [7:0] a, input [8:0] e);
		begin
			expq.push_back(e);
			host.xfer(0, a, 8'h00);
		end
	endtask
	// Read answer stands from the edge after the strobe
	always @(posedge clk) begin
		if (rd_d) cmp("rdata", expq.pop_front(), {hit, rdata});
		rd_d <= rd;
	end
	initial begin
		void'($urandom(32'h93DA2953));
		repeat (6) @(posedge clk);
		#1 rst_b = 1'b1;
		// Reset values, with both neighbours of the window refused
		for (int a = 8'h34; a < 8'h3B; a++) rdx(a[7:0], {a > 8'h34 && a < 8'h3A, 8'h00});
		{tcfg_we, tcfg_rng} = 2'b11;
		@(posedge clk) #1 tcfg_we = 1'b0;
		@(posedge clk) #1 cmp("range", 9'h001, {8'h00, rng});
		// Random bytes, read-only and unused bits among them, read back at once
		for (int a = 8'h35; a < 8'h3A; a++) begin
			v[a - 8'h35] = $urandom;
			host.xfer(1, a[7:0], v[a - 8'h35]);
			rdx(a[7:0], {1'b1, a < 8'h38 ? {2'b01, v[a - 8'h35][5:0]} :
				a == 8'h38 ? v[3] & 8'h2F : v[4]});
		end
		// Field outputs follow the stored bytes
		cmp("tune", {2'b00, v[4][7:2], v[4][0]}, {2'b00, fld});
		cmp("mode", {5'h00, v[3][3:0]}, {5'h00, msel});
		// Run, standby and sleep pick their own set point codes, all within 0..63
		for (int s = 0; s < 3; s++) begin
			{slp, stby} = s[1:0];
			repeat (2) @(posedge clk) #1;
			cmp("state", {1'b0, v[s][5:0], s < 2 || v[3][5], s == 2 && v[3][5]}, {1'b0, act, on, pfm});
		end
		host.xfer(1, 8'h38, v[3] ^ 8'h20);
		repeat (2) @(posedge clk) #1;
		cmp("sleep", {7'h00, !v[3][5], !v[3][5]}, {7'h00, on, pfm});
		repeat (2) @(posedge clk);
		final_report;
	end
	// Watchdog well beyond the fifty-odd cycles of the sequence
	initial begin
		#20000;
		fails++;
		final_report;
	end
endmodule // bkt_buck_two_regs_tb_top
